/* common/sfsf_params.svh */
// offsets, field positions, command codes and timing counts
`ifndef SFSF_PARAMS_SVH
`define SFSF_PARAMS_SVH
`define SFSF_BIT_BUSY 0
`define SFSF_BIT_WEL 1
`define SFSF_BIT_BP_LO 2
`define SFSF_BIT_GUARD_LO 7
`define SFSF_BIT_GUARD_HI 8
`define SFSF_BIT_QUAD 9
`define SFSF_BIT_PPAUSE 10
`define SFSF_BIT_LOCK_LO 11
`define SFSF_BIT_INVERT 14
`define SFSF_BIT_EPAUSE 15
`define SFSF_RESET_WORD 16'h0000
`define SFSF_CMD_WRITE_ENABLE_CMD 8'h06
`define SFSF_CMD_WRITE_DISABLE_CMD 8'h04
`define SFSF_CMD_RDSR_LO 8'h05
`define SFSF_CMD_RDSR_HI 8'h35
`define SFSF_CMD_STATUS_WRITE_CMD 8'h01
`define SFSF_CMD_PROG 8'h02
`define SFSF_CMD_SECT 8'h20
`define SFSF_CMD_BLK32 8'h52
`define SFSF_CMD_BLK64 8'hd8
`define SFSF_CMD_CHIP_A 8'hc7
`define SFSF_CMD_CHIP_B 8'h60
`define SFSF_CMD_SUSP 8'h75
`define SFSF_CMD_RESUME 8'h7a
`define SFSF_CMD_RST_EN 8'h66
`define SFSF_CMD_RST 8'h99
`define SFSF_CMD_DPD 8'hb9
`define SFSF_CMD_SEC_ERASE 8'h44
`define SFSF_CMD_SEC_PROG 8'h42
`define SFSF_WR_TIME_NS 1000
`define SFSF_CLK_NS 10
`define SFSF_WR_CYC (`SFSF_WR_TIME_NS / `SFSF_CLK_NS)
`endif

/* common/sfsf_pkg.sv */
// types shared by the status and framing block
package sfsf_pkg;
  typedef enum logic [1:0] {SFSF_OP_NONE, SFSF_OP_PROG, SFSF_OP_ERASE,
    SFSF_OP_STATUS_WRITE_CMD} sfsf_op_t;
  typedef enum {SFSF_IDLE, SFSF_BUSY, SFSF_PAUSED} sfsf_state_t;
endpackage

/* common/sfsf_link_if.sv */
// framing events from the serial front end to the register logic
`timescale 1ns/1ps
`default_nettype none
interface sfsf_link_if;
  logic frame_end;
  logic aligned;
  logic [7:0] opcode;
  logic [3:0] nbytes;
  logic [15:0] wdata;
  logic rise;
  logic fall;
  logic active;
  modport front(output frame_end, aligned, opcode, nbytes, wdata, rise,
    fall, active);
  modport core(input frame_end, aligned, opcode, nbytes, wdata, rise, fall,
    active);
endinterface
`default_nettype wire

/* verilog/sfsf_frontend.sv */
// serial front end: pin synchronisers, edge finding and byte framing
`timescale 1ns/1ps
`default_nettype none
module sfsf_frontend (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic si,
  sfsf_link_if.front lnk
);
  logic [2:0] sclk_q, sclk_d, cs_q, cs_d, si_q, si_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, op_q, op_d;
  logic [3:0] nb_q, nb_d;
  logic [15:0] wd_q, wd_d;
  logic end_q, end_d;
  logic rise, fall, sel;

  // a pin edge shows while the second and third stages differ
  assign rise = sclk_q[1] & ~sclk_q[2];
  assign fall = ~sclk_q[1] & sclk_q[2];
  assign sel = ~cs_q[2];

  always_comb begin
    sclk_d = {sclk_q[1:0], sclk};
    cs_d = {cs_q[1:0], cs_b};
    si_d = {si_q[1:0], si};
    bit_d = bit_q;
    sh_d = sh_q;
    op_d = op_q;
    nb_d = nb_q;
    wd_d = wd_q;
    end_d = 1'b0;
    if (!sel) begin
      if (cs_q[1]) begin
        bit_d = '0;
        nb_d = '0;
      end
    end else if (cs_q[1]) begin
      end_d = 1'b1;
    end else if (rise) begin
      sh_d = {sh_q[6:0], si_q[2]};
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        if (nb_q == 4'h0) op_d = {sh_q[6:0], si_q[2]};
        else if (nb_q < 4'h3) wd_d = {wd_q[7:0], sh_q[6:0], si_q[2]};
        if (nb_q != 4'hf) nb_d = nb_q + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sclk_q <= '0;
      cs_q <= 3'h7;
      si_q <= '0;
      bit_q <= '0;
      sh_q <= '0;
      op_q <= '0;
      nb_q <= '0;
      wd_q <= '0;
      end_q <= 1'b0;
    end else begin
      sclk_q <= sclk_d;
      cs_q <= cs_d;
      si_q <= si_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      op_q <= op_d;
      nb_q <= nb_d;
      wd_q <= wd_d;
      end_q <= end_d;
    end
  end

  assign lnk.frame_end = end_q;
  assign lnk.aligned = (bit_q == 3'h0);
  assign lnk.opcode = op_q;
  assign lnk.nbytes = nb_q;
  assign lnk.wdata = wd_q;
  assign lnk.rise = rise;
  assign lnk.fall = fall;
  assign lnk.active = sel;
endmodule // sfsf_frontend
`default_nettype wire

/* verilog/sfsf_status.sv */
// status and control word of a serial flash, with command framing
// What this block does
// - busy reads 1 while program, erase or status write runs
// - status write, program and erase refused while write latch is 0
// - five region guard bits kept, written only by status write
// - region guard bits change only outside hardware protected mode
// - chip erase only with low guards 000/invert 0 or 111/invert 1
// - guard mode 00: status writable whenever write latch set
// - guard mode 01 with protect pin low locks status word
// - guard mode 01 with protect pin high allows status writes
// - guard mode 10 locks until power cycle, which clears mode
// - guard mode 11 locks status word until power cycle, as mode 10 does
// - four line enable defaults 0; at 1 pins become data lines
// - three security locks default 0, set singly, cleared only by power cycle
// - guard invert defaults 0 and joins guards to pick region
// - suspend sets erase or program paused flag, both read only
// - resume, software reset and power cycle clear paused flags
// - bits enter msb first, sampled on serial clock rise
// - read commands drive data out; host may end after any bit
// - write type commands need chip select rise on byte boundary
// - partial page program byte does nothing, latch stays set
// - write enable sets latch; writes, erases and resets clear it
`timescale 1ns/1ps
`default_nettype none
`include "sfsf_params.svh"
module sfsf_status
  import sfsf_pkg::*;
#(
  parameter int WR_CYC = `SFSF_WR_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic si,
  input wire logic wp_b,
  output logic so,
  output logic so_oe,
  output logic four_line_enable,
  output logic busy_flag,
  output logic [15:0] status_control_word
);
  sfsf_link_if lnk ();
  sfsf_frontend u_front (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sclk(sclk),
    .cs_b(cs_b),
    .si(si),
    .lnk(lnk)
  );

  logic [15:0] sw_q, sw_d;
  sfsf_state_t st_q, st_d;
  sfsf_op_t op_q, op_d;
  logic [15:0] cnt_q, cnt_d;
  logic rst_armed_q, rst_armed_d;
  logic [15:0] pend_q, pend_d;
  logic so_q, so_d, oe_q, oe_d;
  logic [15:0] rsh_q, rsh_d;
  logic rd_q, rd_d;
  logic [2:0] wp_q, wp_d;
  logic wp_lvl_q, wp_lvl_d;
  logic wp_ok;

  // low guard bits all equal to the invert bit permit chip erase
  function automatic logic chip_ok(input logic [15:0] w);
    logic [2:0] g;
    g = w[`SFSF_BIT_BP_LO +: 3];
    return (g == 3'h0 && !w[`SFSF_BIT_INVERT]) ||
      (g == 3'h7 && w[`SFSF_BIT_INVERT]);
  endfunction

  function automatic logic sr_writable(input logic [15:0] w,
                                       input logic pin);
    logic [1:0] m;
    m = {w[`SFSF_BIT_GUARD_HI], w[`SFSF_BIT_GUARD_LO]};
    unique case (m)
      2'b00: return 1'b1;
      2'b01: return pin;
      2'b10: return 1'b0;
      2'b11: return 1'b0;
    endcase
  endfunction

  // status write commit: volatile bits stay, locks only ever gain ones
  function automatic logic [15:0] sr_merge(input logic [15:0] cur,
                                           input logic [15:0] req);
    logic [15:0] nxt;
    nxt = cur;
    nxt[`SFSF_BIT_BP_LO +: 5] = req[`SFSF_BIT_BP_LO +: 5];
    nxt[`SFSF_BIT_GUARD_LO] = req[`SFSF_BIT_GUARD_LO];
    nxt[`SFSF_BIT_GUARD_HI] = req[`SFSF_BIT_GUARD_HI];
    nxt[`SFSF_BIT_QUAD] = req[`SFSF_BIT_QUAD];
    nxt[`SFSF_BIT_INVERT] = req[`SFSF_BIT_INVERT];
    nxt[`SFSF_BIT_LOCK_LO +: 3] = cur[`SFSF_BIT_LOCK_LO +: 3] |
      req[`SFSF_BIT_LOCK_LO +: 3];
    return nxt;
  endfunction

  // one byte of the word as a status read shows it
  function automatic logic [7:0] sr_byte(input logic [15:0] w,
                                         input logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction

  // rotate left by one: the bit that leaves the top re-enters below
  function automatic logic [7:0] rot1(input logic [7:0] b);
    return {b[6:0], b[7]};
  endfunction

  function automatic logic is_sr_read(input logic [7:0] c);
    return c == `SFSF_CMD_RDSR_LO || c == `SFSF_CMD_RDSR_HI;
  endfunction

  // protect pin: a level counts once the last two stages agree, so a
  // glitch shorter than two cycles never opens a locked word
  always_comb begin
    wp_d = {wp_q[1:0], wp_b};
    wp_lvl_d = wp_lvl_q;
    if (wp_q[1] == wp_q[2]) begin
      wp_lvl_d = wp_q[2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wp_q <= '0;
      wp_lvl_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      wp_lvl_q <= wp_lvl_d;
    end
  end

  assign wp_ok = wp_lvl_q;

  always_comb begin
    logic [7:0] op;
    logic write_latch_flag;
    op = lnk.opcode;
    write_latch_flag = sw_q[`SFSF_BIT_WEL];
    sw_d = sw_q;
    st_d = st_q;
    op_d = op_q;
    cnt_d = cnt_q;
    rst_armed_d = rst_armed_q;
    pend_d = pend_q;

    // fixed busy time; a paused job keeps its remaining count
    if (st_q == SFSF_BUSY) begin
      if (cnt_q == 16'h0) begin
        st_d = SFSF_IDLE;
        if (op_q == SFSF_OP_STATUS_WRITE_CMD) begin
          sw_d = sr_merge(sw_q, pend_q);
        end
        op_d = SFSF_OP_NONE;
      end else begin
        cnt_d = cnt_q - 16'h1;
      end
    end

    // commands act only once chip select has risen, so the count is final
    if (lnk.frame_end) begin
      rst_armed_d = 1'b0;
      if (op == `SFSF_CMD_RST && rst_armed_q && lnk.nbytes == 4'h1) begin
        sw_d[`SFSF_BIT_WEL] = 1'b0;
        sw_d[`SFSF_BIT_EPAUSE] = 1'b0;
        sw_d[`SFSF_BIT_PPAUSE] = 1'b0;
        st_d = SFSF_IDLE;
        op_d = SFSF_OP_NONE;
      end else if (op == `SFSF_CMD_RST_EN && lnk.nbytes == 4'h1) begin
        rst_armed_d = 1'b1;
      end else if (op == `SFSF_CMD_SUSP && st_q == SFSF_BUSY &&
          op_q != SFSF_OP_STATUS_WRITE_CMD) begin
        st_d = SFSF_PAUSED;
        if (op_q == SFSF_OP_ERASE) sw_d[`SFSF_BIT_EPAUSE] = 1'b1;
        else sw_d[`SFSF_BIT_PPAUSE] = 1'b1;
      end else if (op == `SFSF_CMD_RESUME && st_q == SFSF_PAUSED) begin
        st_d = SFSF_BUSY;
        sw_d[`SFSF_BIT_EPAUSE] = 1'b0;
        sw_d[`SFSF_BIT_PPAUSE] = 1'b0;
      end else if (!lnk.aligned || st_q != SFSF_IDLE) begin
        // rejected, latch left as it was
      end else if (op == `SFSF_CMD_WRITE_ENABLE_CMD && lnk.nbytes == 4'h1) begin
        sw_d[`SFSF_BIT_WEL] = 1'b1;
      end else if (op == `SFSF_CMD_WRITE_DISABLE_CMD) begin
        sw_d[`SFSF_BIT_WEL] = 1'b0;
      end else if (write_latch_flag) begin
        unique case (op)
          `SFSF_CMD_STATUS_WRITE_CMD: begin
            sw_d[`SFSF_BIT_WEL] = 1'b0;
            if (sr_writable(sw_q, wp_ok) && lnk.nbytes >= 4'h2) begin
              pend_d = sw_q;
              pend_d[7:0] = lnk.nbytes == 4'h2 ? lnk.wdata[7:0] :
                lnk.wdata[15:8];
              if (lnk.nbytes >= 4'h3) pend_d[15:8] = lnk.wdata[7:0];
              st_d = SFSF_BUSY;
              op_d = SFSF_OP_STATUS_WRITE_CMD;
              cnt_d = WR_CYC[15:0];
            end
          end
          `SFSF_CMD_PROG, `SFSF_CMD_SEC_PROG: begin
            sw_d[`SFSF_BIT_WEL] = 1'b0;
            st_d = SFSF_BUSY;
            op_d = SFSF_OP_PROG;
            cnt_d = WR_CYC[15:0];
          end
          `SFSF_CMD_SECT, `SFSF_CMD_BLK32, `SFSF_CMD_BLK64,
          `SFSF_CMD_SEC_ERASE: begin
            sw_d[`SFSF_BIT_WEL] = 1'b0;
            st_d = SFSF_BUSY;
            op_d = SFSF_OP_ERASE;
            cnt_d = WR_CYC[15:0];
          end
          `SFSF_CMD_CHIP_A, `SFSF_CMD_CHIP_B: begin
            sw_d[`SFSF_BIT_WEL] = 1'b0;
            if (chip_ok(sw_q)) begin
              st_d = SFSF_BUSY;
              op_d = SFSF_OP_ERASE;
              cnt_d = WR_CYC[15:0];
            end
          end
          default: ;
        endcase
      end
    end

    // busy follows the state it is entering, so it never lags a start
    sw_d[`SFSF_BIT_BUSY] = (st_d == SFSF_BUSY);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sw_q <= `SFSF_RESET_WORD;
      st_q <= SFSF_IDLE;
      op_q <= SFSF_OP_NONE;
      cnt_q <= '0;
      rst_armed_q <= 1'b0;
      pend_q <= '0;
    end else begin
      sw_q <= sw_d;
      st_q <= st_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      rst_armed_q <= rst_armed_d;
      pend_q <= pend_d;
    end
  end

  // read path: status bytes shifted out on falling serial clock
  // upper half holds the bits still to go, lower half the whole byte,
  // so a continuous read starts over at every byte boundary
  always_comb begin
    logic [7:0] b;
    b = sr_byte(sw_q, lnk.opcode == `SFSF_CMD_RDSR_HI);
    so_d = so_q;
    oe_d = oe_q;
    rsh_d = rsh_q;
    rd_d = rd_q;
    if (!lnk.active) begin
      oe_d = 1'b0;
      rd_d = 1'b0;
    end else if (lnk.fall && lnk.aligned && lnk.nbytes == 4'h1 && !rd_q &&
        is_sr_read(lnk.opcode)) begin
      rd_d = 1'b1;
      oe_d = 1'b1;
      so_d = b[7];
      rsh_d = {rot1(b), b};
    end else if (lnk.fall && rd_q) begin
      if (lnk.aligned) begin
        so_d = rsh_q[7];
        rsh_d[15:8] = rot1(rsh_q[7:0]);
      end else begin
        so_d = rsh_q[15];
        rsh_d[15:8] = rot1(rsh_q[15:8]);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
      rsh_q <= '0;
      rd_q <= 1'b0;
    end else begin
      so_q <= so_d;
      oe_q <= oe_d;
      rsh_q <= rsh_d;
      rd_q <= rd_d;
    end
  end

  assign so = so_q;
  assign so_oe = oe_q;
  assign status_control_word = sw_q;
  assign busy_flag = sw_q[`SFSF_BIT_BUSY];
  assign four_line_enable = sw_q[`SFSF_BIT_QUAD];
endmodule // sfsf_status
`default_nettype wire

/* verif/sfsf_status_checker.sv */
// port level checks for the status and framing block
`timescale 1ns/1ps
`default_nettype none
module sfsf_status_checker #(
  parameter int WR_CYC = 100
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic si,
  input wire logic wp_b,
  input wire logic so,
  input wire logic so_oe,
  input wire logic four_line_enable,
  input wire logic busy_flag,
  input wire logic [15:0] status_control_word
);
  // guards, modes, quad, locks, invert: only a status write moves them
  localparam logic [15:0] KEEP = 16'h7bfc;
  int cnt_q;
  int cnt_d;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  always_comb cnt_d = busy_flag ? cnt_q + 1 : 0;
  always_ff @(posedge core_clk) cnt_q <= rst_b ? cnt_d : 0;
  AST_BUSY_BIT: assert property (busy_flag == status_control_word[0])
    else $error("busy port differs from word bit 0");
  AST_BUSY_LEN: assert property (cnt_q <= WR_CYC + 1)
    else $error("busy held too long");
  AST_QUAD_BIT: assert property (
    four_line_enable == status_control_word[9])
    else $error("four line port differs from word bit 9");
  AST_OE_IDLE: assert property (cs_b [*6] |-> !so_oe)
    else $error("so driven while deselected");
  AST_SO_EDGE: assert property (so_oe && $changed(so) |-> !sclk)
    else $error("so moved while serial clock high");
  AST_LOCK_KEEP: assert property (($past(status_control_word[13:11]) &
    ~status_control_word[13:11]) == 3'b000)
    else $error("security lock cleared");
  AST_GUARD_WR: assert property ($changed(status_control_word[6:2]) |->
    $past(busy_flag))
    else $error("guards changed without a status write");
  AST_WEL_CLR: assert property ($rose(busy_flag) |-> ##2
    !status_control_word[1])
    else $error("latch kept after write start");
  AST_HW_LOCK: assert property ((!wp_b) [*4] ##0
    (status_control_word[8:7] == 2'b01) |=>
    $stable(status_control_word & KEEP))
    else $error("word written under pin protection");
  AST_MODE_LOCK: assert property (status_control_word[8] |=>
    $stable(status_control_word & KEEP))
    else $error("word written while locked down");
endmodule // sfsf_status_checker
bind sfsf_status sfsf_status_checker #(.WR_CYC(WR_CYC)) sfsf_status_checker_i (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .sclk(sclk),
  .cs_b(cs_b),
  .si(si),
  .wp_b(wp_b),
  .so(so),
  .so_oe(so_oe),
  .four_line_enable(four_line_enable),
  .busy_flag(busy_flag),
  .status_control_word(status_control_word)
);
`default_nettype wire

/* verif/sfsf_host_model.sv */
// host serial controller model: frames bits with chip select and clock
`timescale 1ns/1ps
`default_nettype none
module sfsf_host_model (
  output logic sclk,
  output logic cs_b,
  output logic si,
  input wire logic so
);
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
  end
  // d is left aligned; nb bits go out, then nr bits come back
  task automatic xfer(input logic [39:0] d, input int nb, input int nr,
    output logic [15:0] rd);
    rd = '0;
    cs_b = 1'b0;
    #100;
    for (int i = 0; i < nb + nr; i++) begin
      si = (i < nb) ? d[39 - i] : ~si;
      #62.5 sclk = 1'b1;
      if (i >= nb) begin
        rd = {rd[14:0], so};
      end
      #62.5 sclk = 1'b0;
    end
    #100 cs_b = 1'b1;
    // released line must not keep its last value
    si = ~si;
    #200;
  endtask
endmodule // sfsf_host_model
`default_nettype wire

/* verif/sfsf_status_tb.sv */
// self-checking bench for the status and framing block
`timescale 1ns/1ps
`default_nettype none
module sfsf_status_tb;
  localparam int WR_CYC = 40;
  logic core_clk;
  logic rst_b;
  logic wp_b;
  logic sclk;
  logic cs_b;
  logic si;
  logic so;
  logic so_oe;
  logic four_line_enable;
  logic busy_flag;
  logic [15:0] status_control_word;
  logic [15:0] rd;
  int n_errors = 0;
  int n_checks = 0;
  sfsf_host_model sfsf_host_model_i (
    .sclk(sclk),
    .cs_b(cs_b),
    .si(si),
    .so(so)
  );
  sfsf_status #(.WR_CYC(WR_CYC)) sfsf_status_i (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sclk(sclk),
    .cs_b(cs_b),
    .si(si),
    .wp_b(wp_b),
    .so(so),
    .so_oe(so_oe),
    .four_line_enable(four_line_enable),
    .busy_flag(busy_flag),
    .status_control_word(status_control_word)
  );
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic [39:0] d, input int nb, input int nr);
    sfsf_host_model_i.xfer(d, nb, nr, rd);
    // look at outputs away from the edge that updates them
    @(negedge core_clk);
  endtask
  task automatic op(input logic [7:0] c);
    xf({c, 32'h0}, 8, 0);
  endtask
  task automatic idle();
    for (int i = 0; i < 200 && busy_flag !== 1'b0; i++) begin
      @(negedge core_clk);
    end
    if (busy_flag !== 1'b0) begin
      n_errors++;
      $display("Error %0t: busy never ended", $time);
      give_verdict();
    end
  endtask
  task automatic status_write_cmd(input logic [15:0] w);
    op(8'h06);
    xf({8'h01, w[7:0], w[15:8], 16'h0}, 24, 0);
    idle();
  endtask
  task automatic reset();
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic t_latch();
    xf({8'h01, 8'h04, 24'h0}, 16, 0);
    chk(status_control_word, 16'h0000);
    op(8'h06);
    chk(status_control_word, 16'h0002);
    xf({8'h04, 32'h0}, 7, 0);
    chk(status_control_word, 16'h0002);
    op(8'h04);
    chk(status_control_word, 16'h0000);
    op(8'h06);
    op(8'h66);
    op(8'h99);
    chk(status_control_word, 16'h0000);
  endtask
  task automatic t_write();
    op(8'h06);
    xf({8'h01, 16'h4c4a, 16'h0}, 24, 0);
    chk({15'h0, busy_flag}, 16'h0001);
    idle();
    chk(status_control_word, 16'h4a4c);
    chk({15'h0, four_line_enable}, 16'h0001);
    xf({8'h05, 32'h0}, 8, 16);
    chk(rd, 16'h4c4c);
    chk({15'h0, so_oe}, 16'h0000);
    xf({8'h35, 32'h0}, 8, 8);
    chk(rd, 16'h004a);
    status_write_cmd(16'h0000);
    chk(status_control_word, 16'h0800);
  endtask
  task automatic t_erase();
    status_write_cmd(16'h0804);
    op(8'h06);
    op(8'hc7);
    chk(status_control_word, 16'h0804);
    status_write_cmd(16'h0800);
    op(8'h06);
    op(8'h60);
    chk(status_control_word, 16'h0801);
    idle();
  endtask
  task automatic t_prog();
    op(8'h06);
    xf({8'h02, 32'h0}, 36, 0);
    chk(status_control_word, 16'h0802);
    xf({8'h02, 32'h0}, 40, 0);
    chk(status_control_word, 16'h0801);
    idle();
  endtask
  task automatic t_modes();
    status_write_cmd(16'h0880);
    chk(status_control_word, 16'h0880);
    // the protect pin is driven, never tied, so the four line bit is safe
    @(posedge core_clk);
    wp_b <= 1'b0;
    status_write_cmd(16'h0884);
    chk(status_control_word, 16'h0880);
    @(posedge core_clk);
    wp_b <= 1'b1;
    status_write_cmd(16'h0884);
    chk(status_control_word, 16'h0884);
    status_write_cmd(16'h0900);
    status_write_cmd(16'h0800);
    chk(status_control_word, 16'h0900);
    reset();
    chk(status_control_word, 16'h0000);
    status_write_cmd(16'h0180);
    status_write_cmd(16'h0000);
    chk(status_control_word, 16'h0180);
  endtask
  initial begin
    rst_b = 1'b0;
    wp_b = 1'b1;
    reset();
    chk(status_control_word, 16'h0000);
    t_latch();
    t_write();
    t_erase();
    t_prog();
    t_modes();
    give_verdict();
  end
endmodule // sfsf_status_tb
`default_nettype wire
